// [shared/ddc_sel_pkg.sv]
// Package holding the register map, field layout, reset values and encodings
// of the downconverter input and oscillator channel select block.
// Assumes a 32-bit APB bus with word-aligned registers.
package ddc_sel_pkg;

   // Register indices; byte address is four times the index.
   localparam logic [15:0] DECIM_CTRL_IDX   = 16'h0310;
   localparam logic [15:0] INPUT_ROUTE_IDX  = 16'h0311;
   localparam logic [15:0] OSC_CTRL_IDX     = 16'h0314;
   localparam logic [15:0] SEL_STATUS_IDX   = 16'h031f;
   localparam logic [15:0] DECIM_CTRL_ADDR  = 16'(DECIM_CTRL_IDX << 2);
   localparam logic [15:0] INPUT_ROUTE_ADDR = 16'(INPUT_ROUTE_IDX << 2);
   localparam logic [15:0] OSC_CTRL_ADDR    = 16'(OSC_CTRL_IDX << 2);
   localparam logic [15:0] SEL_STATUS_ADDR  = 16'(SEL_STATUS_IDX << 2);

   // Reset values.
   localparam logic [3:0] DECIM_CTRL_RST  = 4'h0;
   localparam logic [7:0] INPUT_ROUTE_RST = 8'h00;
   localparam logic [7:0] OSC_CTRL_RST    = 8'h00;

   // Field positions.
   localparam int C2R_BIT      = 3;
   localparam int I_SEL_BIT    = 0;
   localparam int Q_SEL_BIT    = 2;
   localparam int EXT_LSB      = 4;
   localparam int MODE_LSB     = 4;
   localparam int ST_UNSUP_BIT = 4;
   localparam int ST_BAD_BIT   = 5;

   // Primary and extended decimation codes.
   localparam logic [2:0] PRIM_USE_EXT = 3'h7;
   localparam logic [3:0] EXT_TB1      = 4'h7;
   localparam logic [3:0] EXT_FB2_TB1  = 4'h8;
   localparam logic [3:0] EXT_HB2_FB2  = 4'h9;

   // Channel selection modes.
   localparam logic [3:0] MODE_REG    = 4'h0;
   localparam logic [3:0] MODE_PINS   = 4'h1;
   localparam logic [3:0] MODE_EDGE_A = 4'h8;
   localparam logic [3:0] MODE_EDGE_B = 4'ha;

   // Filter enable vector bit positions.
   localparam int F_HB1 = 0;
   localparam int F_HB2 = 1;
   localparam int F_HB3 = 2;
   localparam int F_HB4 = 3;
   localparam int F_TB2 = 4;
   localparam int F_TB1 = 5;
   localparam int F_FB2 = 6;

   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b00,
      BUS_ANSWER = 2'b01
   } bus_state_t;

endpackage

// [shared/chan_step_if.sv]
// Interface joining the select logic to the edge-stepped channel counter.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/100ps
`default_nettype none
interface chan_step_if;
   logic       step_on_low;
   logic       step_on_high;
   logic       pin_low;
   logic       pin_high;
   logic [3:0] last_chan;
   logic [3:0] count;

   modport ctl (
      output step_on_low,
      output step_on_high,
      output pin_low,
      output pin_high,
      output last_chan,
      input  count
   );

   modport cnt (
      input  step_on_low,
      input  step_on_high,
      input  pin_low,
      input  pin_high,
      input  last_chan,
      output count
   );
endinterface
`default_nettype wire

// [core/chan_step_counter.sv]
// Channel counter that steps on rising edges of a selection pin.
// Assumes pins are already synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module chan_step_counter (
   input  wire logic   pclk,
   input  wire logic   presetn,
   input  wire logic   ce,
   chan_step_if.cnt    stp
);
   import ddc_sel_pkg::*;

   logic       low_prev_ff;
   logic       high_prev_ff;
   logic [3:0] count_ff;
   logic [3:0] nxt_count;
   logic       edge_seen;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_prev_ff  <= 1'b0;
         high_prev_ff <= 1'b0;
      end else if (ce) begin
         low_prev_ff  <= stp.pin_low;
         high_prev_ff <= stp.pin_high;
      end
   end

   assign edge_seen = (stp.step_on_low && stp.pin_low && !low_prev_ff)     // [RULE8]
                   || (stp.step_on_high && stp.pin_high && !high_prev_ff); // [RULE9]

   // Greater-or-equal also recovers when software lowers the last channel.
   always_comb begin
      nxt_count = count_ff;
      if (!stp.step_on_low && !stp.step_on_high) begin
         nxt_count = 4'h0;
      end else if (edge_seen) begin
         if (count_ff >= stp.last_chan) begin
            nxt_count = 4'h0; // [RULE10]
         end else begin
            nxt_count = 4'(count_ff + 4'h1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= 4'h0;
      end else if (ce) begin
         count_ff <= nxt_count;
      end
   end

   assign stp.count = count_ff;
endmodule
`default_nettype wire

// [core/ddc_input_and_nco_channel_select.sv]
// Register bank and selection logic for the first downconverter: decimation
// choice, input routing and active oscillator channel.
// Assumes an APB master on pclk and selection pins synchronous to pclk.
//
// Overview of operation
// RULE1: Extended code 111 selects third-band, decimate 3.
// RULE2: Extended code 1000 cascades fifth/third-band, decimate 15.
// RULE3: Extended code 1001 adds half-band two, decimate 30.
// RULE4: Routing bit 2 picks quadrature source A/B.
// RULE5: Routing bit 0 picks in-phase source A/B.
// RULE6: Mode 0 takes channel from register field.
// RULE7: Mode 1 takes channel from two pins.
// RULE8: Mode 1000 steps counter on low pin rise.
// RULE9: Mode 1010 steps counter on high pin rise.
// RULE10: Counter wraps after reaching register channel field.
// RULE11: Channel field is plain binary, resets zero.
// RULE12: Sixteen channels, code 1111 is channel 15.
// RULE13: Extended field only when primary is 111.
// RULE14: Mixer uses selected channel; reserved bits read zero.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ddc_input_and_nco_channel_select (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [15:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        select_pin_low,
   input  wire logic        select_pin_high,
   output logic             i_source_b,
   output logic             q_source_b,
   output logic      [3:0]  active_channel,
   output logic      [6:0]  filter_enable,
   output logic      [5:0]  decim_factor,
   output logic             c2r_enable,
   output logic             real_rate_unsupported,
   output logic             decim_code_invalid
);
   import ddc_sel_pkg::*;

   chan_step_if stp ();
   bus_state_t  bus_state_ff;
   bus_state_t  nxt_bus_state;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        addr_hit;
   logic        wr_take;
   logic [3:0]  decim_ctrl_ff;
   logic [7:0]  input_route_ff;
   logic [7:0]  osc_ctrl_ff;
   logic [3:0]  mode;
   logic [3:0]  reg_chan;
   logic [3:0]  nxt_chan;
   logic [3:0]  chan_ff;
   logic [6:0]  nxt_filters;
   logic [5:0]  nxt_factor;
   logic        nxt_unsup;
   logic        nxt_bad;
   logic [6:0]  filters_ff;
   logic [5:0]  factor_ff;
   logic        c2r_ff;
   logic        unsup_ff;
   logic        bad_ff;
   logic        i_src_ff;
   logic        q_src_ff;

   assign mode     = osc_ctrl_ff[MODE_LSB +: 4];
   assign reg_chan = osc_ctrl_ff[3:0];

   // APB slave: no wait states. The answer is prepared in the setup cycle,
   // so pready rises in the first access cycle straight from a flop.
   assign addr_hit = (paddr == DECIM_CTRL_ADDR) || (paddr == INPUT_ROUTE_ADDR)
                  || (paddr == OSC_CTRL_ADDR) || (paddr == SEL_STATUS_ADDR);
   assign wr_take  = psel && penable && pready_ff && pwrite && addr_hit;

   always_comb begin
      nxt_bus_state = bus_state_ff;
      case (bus_state_ff)
         BUS_IDLE: begin
            if (psel && !penable) begin
               nxt_bus_state = BUS_ANSWER;
            end
         end
         BUS_ANSWER: begin
            nxt_bus_state = BUS_IDLE;
         end
         default: begin
            nxt_bus_state = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state_ff <= BUS_IDLE;
      end else if (ce) begin
         bus_state_ff <= nxt_bus_state;
      end
   end

   // Reserved bits and unused upper bits read back as zero.
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      if (!pwrite) begin
         case (paddr)
            DECIM_CTRL_ADDR: begin
               nxt_prdata[3:0] = decim_ctrl_ff;
            end
            INPUT_ROUTE_ADDR: begin
               nxt_prdata[7:0] = input_route_ff & 8'hf5; // [RULE14]
            end
            OSC_CTRL_ADDR: begin
               nxt_prdata[7:0] = osc_ctrl_ff;
            end
            SEL_STATUS_ADDR: begin
               nxt_prdata[3:0]          = chan_ff;
               nxt_prdata[ST_UNSUP_BIT] = unsup_ff;
               nxt_prdata[ST_BAD_BIT]   = bad_ff;
            end
            default: begin
               nxt_prdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else if (ce) begin
         if (bus_state_ff == BUS_IDLE && psel && !penable) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= !addr_hit;
            prdata_ff  <= nxt_prdata;
         end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
         end
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // Configuration registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         decim_ctrl_ff <= DECIM_CTRL_RST;
      end else if (ce && wr_take && paddr == DECIM_CTRL_ADDR) begin
         decim_ctrl_ff <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_route_ff <= INPUT_ROUTE_RST; // [RULE4] [RULE5]
      end else if (ce && wr_take && paddr == INPUT_ROUTE_ADDR) begin
         input_route_ff <= pwdata[7:0] & 8'hf5; // [RULE14]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_ctrl_ff <= OSC_CTRL_RST; // [RULE11]
      end else if (ce && wr_take && paddr == OSC_CTRL_ADDR) begin
         osc_ctrl_ff <= pwdata[7:0];
      end
   end

   // Input routing for the in-phase and quadrature paths.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         i_src_ff <= 1'b0;
         q_src_ff <= 1'b0;
      end else if (ce) begin
         i_src_ff <= input_route_ff[I_SEL_BIT]; // [RULE5]
         q_src_ff <= input_route_ff[Q_SEL_BIT]; // [RULE4]
      end
   end

   assign i_source_b = i_src_ff;
   assign q_source_b = q_src_ff;

   // Decimation decode. Factors are given for complex output; with
   // complex-to-real on, the rate halves except for the third-band codes,
   // which cannot halve and are flagged instead.
   always_comb begin
      nxt_filters = 7'h00;
      nxt_factor  = 6'h00;
      nxt_bad     = 1'b0;
      case (decim_ctrl_ff[2:0])
         3'h0: begin
            nxt_filters[F_HB1] = 1'b1;
            nxt_filters[F_HB2] = 1'b1;
            nxt_factor         = 6'h04;
         end
         3'h1: begin
            nxt_filters[F_HB1] = 1'b1;
            nxt_filters[F_HB2] = 1'b1;
            nxt_filters[F_HB3] = 1'b1;
            nxt_factor         = 6'h08;
         end
         3'h2: begin
            nxt_filters[3:0] = 4'hf;
            nxt_factor       = 6'h10;
         end
         3'h3: begin
            nxt_filters[F_HB1] = 1'b1;
            nxt_factor         = 6'h02;
         end
         3'h4: begin
            nxt_filters[F_HB1] = 1'b1;
            nxt_filters[F_TB2] = 1'b1;
            nxt_factor         = 6'h06;
         end
         3'h5: begin
            nxt_filters[F_HB1] = 1'b1;
            nxt_filters[F_HB2] = 1'b1;
            nxt_filters[F_TB2] = 1'b1;
            nxt_factor         = 6'h0c;
         end
         3'h6: begin
            nxt_filters[2:0]   = 3'h7;
            nxt_filters[F_TB2] = 1'b1;
            nxt_factor         = 6'h18;
         end
         PRIM_USE_EXT: begin
            // Decoded below from the extended field.
         end
         default: begin
            nxt_bad = 1'b1;
         end
      endcase
      if (decim_ctrl_ff[2:0] == PRIM_USE_EXT) begin // [RULE13]
         case (input_route_ff[EXT_LSB +: 4])
            4'h0: begin
               nxt_filters[4:0] = 5'h1f;
               nxt_factor       = 6'h30;
            end
            4'h2: begin
               nxt_filters[F_HB1] = 1'b1;
               nxt_filters[F_FB2] = 1'b1;
               nxt_factor         = 6'h0a;
            end
            4'h3: begin
               nxt_filters[F_HB1] = 1'b1;
               nxt_filters[F_HB2] = 1'b1;
               nxt_filters[F_FB2] = 1'b1;
               nxt_factor         = 6'h14;
            end
            4'h4: begin
               nxt_filters[2:0]   = 3'h7;
               nxt_filters[F_FB2] = 1'b1;
               nxt_factor         = 6'h28;
            end
            EXT_TB1: begin
               nxt_filters[F_TB1] = 1'b1; // [RULE1]
               nxt_factor         = 6'h03;
            end
            EXT_FB2_TB1: begin
               nxt_filters[F_FB2] = 1'b1; // [RULE2]
               nxt_filters[F_TB1] = 1'b1;
               nxt_factor         = 6'h0f;
            end
            EXT_HB2_FB2: begin
               nxt_filters[F_HB2] = 1'b1; // [RULE3]
               nxt_filters[F_FB2] = 1'b1;
               nxt_filters[F_TB1] = 1'b1;
               nxt_factor         = 6'h1e;
            end
            default: begin
               nxt_bad = 1'b1;
            end
         endcase
      end
   end

   // Odd third-band ratios cannot halve, so real output keeps the factor.
   always_comb begin
      nxt_unsup = 1'b0;
      if (decim_ctrl_ff[C2R_BIT] && !nxt_bad && nxt_filters[F_TB1]) begin
         nxt_unsup = 1'b1; // [RULE1] [RULE2] [RULE3]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filters_ff <= 7'h00;
         factor_ff  <= 6'h00;
         c2r_ff     <= 1'b0;
         unsup_ff   <= 1'b0;
         bad_ff     <= 1'b0;
      end else if (ce) begin
         filters_ff <= nxt_filters;
         c2r_ff     <= decim_ctrl_ff[C2R_BIT];
         unsup_ff   <= nxt_unsup;
         bad_ff     <= nxt_bad;
         if (decim_ctrl_ff[C2R_BIT] && !nxt_unsup) begin
            factor_ff <= nxt_factor >> 1;
         end else begin
            factor_ff <= nxt_factor;
         end
      end
   end

   assign filter_enable         = filters_ff;
   assign decim_factor          = factor_ff;
   assign c2r_enable            = c2r_ff;
   assign real_rate_unsupported = unsup_ff;
   assign decim_code_invalid    = bad_ff;

   // Oscillator channel selection.
   assign stp.step_on_low  = (mode == MODE_EDGE_A);
   assign stp.step_on_high = (mode == MODE_EDGE_B);
   assign stp.pin_low      = select_pin_low;
   assign stp.pin_high     = select_pin_high;
   assign stp.last_chan    = reg_chan; // [RULE10]

   chan_step_counter chan_step_counter_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .stp     (stp)
   );

   // Undefined modes fall back to the register field.
   always_comb begin
      case (mode)
         MODE_REG: begin
            nxt_chan = reg_chan; // [RULE6] [RULE11]
         end
         MODE_PINS: begin
            nxt_chan = {2'b00, select_pin_high, select_pin_low}; // [RULE7]
         end
         MODE_EDGE_A, MODE_EDGE_B: begin
            nxt_chan = stp.count; // [RULE8] [RULE9]
         end
         default: begin
            nxt_chan = reg_chan;
         end
      endcase
   end

   // Full 4-bit index reaches all sixteen channels, 0 to 15.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_ff <= 4'h0;
      end else if (ce) begin
         chan_ff <= nxt_chan; // [RULE12] [RULE14]
      end
   end

   assign active_channel = chan_ff;
endmodule
`default_nettype wire

// [dv/pin_partner.sv]
// External logic that drives the two channel selection pins.
// Assumes the bench asks for pin levels just after a rising pclk edge.
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic req_low,
   input  wire logic req_high,
   output logic      select_pin_low,
   output logic      select_pin_high
);
   // Pins move only just after an edge, as a synchronous source would.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         select_pin_low  <= 1'b0;
         select_pin_high <= 1'b0;
      end else begin
         select_pin_low  <= req_low;
         select_pin_high <= req_high;
      end
   end
endmodule
`default_nettype wire

// [dv/ddc_sel_assertions.sv]
// Checker for the downconverter select block, bound to its top ports.
// Assumes ce is held high, so register effects land in fixed cycles.
`timescale 1ns/100ps
`default_nettype none
module ddc_sel_assertions
   import ddc_sel_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        select_pin_low,
   input wire logic        select_pin_high,
   input wire logic        i_source_b,
   input wire logic        q_source_b,
   input wire logic [3:0]  active_channel,
   input wire logic [6:0]  filter_enable,
   input wire logic [5:0]  decim_factor
);
   wire logic       wr_done = psel && penable && pready && pwrite && !pslverr;
   logic      [2:0] prim_ff;
   logic            c2r_ff;
   logic      [3:0] ext_ff;
   logic      [3:0] mode_ff;
   logic      [3:0] chan_ff;
   logic      [3:0] age_ff;
   wire logic       settled = age_ff >= 4'h2;

   // Shadow copies let the checks wait until a new setting has worked through.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prim_ff <= 3'h0;
         c2r_ff  <= 1'b0;
         ext_ff  <= 4'h0;
         mode_ff <= 4'h0;
         chan_ff <= 4'h0;
         age_ff  <= 4'h0;
      end else if (wr_done) begin
         age_ff <= 4'h0;
         if (paddr == DECIM_CTRL_ADDR) begin
            prim_ff <= pwdata[2:0];
            c2r_ff  <= pwdata[C2R_BIT];
         end
         if (paddr == INPUT_ROUTE_ADDR) begin
            ext_ff <= pwdata[7:4];
         end
         if (paddr == OSC_CTRL_ADDR) begin
            mode_ff <= pwdata[7:4];
            chan_ff <= pwdata[3:0];
         end
      end else if (age_ff != 4'hf) begin
         age_ff <= age_ff + 4'h1;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   route_write_a: assert property (
      wr_done && paddr == INPUT_ROUTE_ADDR |-> ##2 i_source_b == $past(pwdata[I_SEL_BIT], 2)
      && q_source_b == $past(pwdata[Q_SEL_BIT], 2)) else $error("routing bits missed a write");
   reserved_zero_a: assert property (
      psel && penable && pready && !pwrite && paddr == INPUT_ROUTE_ADDR
      |-> prdata[3] == 1'b0 && prdata[1] == 1'b0) else $error("reserved routing bits read one");
   reg_channel_a: assert property (
      settled && mode_ff == MODE_REG |-> active_channel == chan_ff)
      else $error("channel differs from register field");
   pin_channel_a: assert property (
      settled && mode_ff == MODE_PINS && $stable({select_pin_high, select_pin_low})
      |-> active_channel == {2'b00, select_pin_high, select_pin_low})
      else $error("channel differs from pin levels");
   step_low_a: assert property (
      settled && mode_ff == MODE_EDGE_A && $changed(active_channel)
      |-> $past(select_pin_low, 2) && !$past(select_pin_low, 3))
      else $error("channel moved without a low pin rise");
   step_high_a: assert property (
      settled && mode_ff == MODE_EDGE_B && $changed(active_channel)
      |-> $past(select_pin_high, 2) && !$past(select_pin_high, 3))
      else $error("channel moved without a high pin rise");
   wrap_limit_a: assert property (
      settled && (mode_ff == MODE_EDGE_A || mode_ff == MODE_EDGE_B) |-> active_channel <= chan_ff)
      else $error("counter passed its last channel");
   third_band_a: assert property (
      settled && prim_ff == PRIM_USE_EXT && ext_ff == EXT_TB1
      |-> filter_enable == 7'h20 && decim_factor == 6'h03) else $error("code 7 decode wrong");
   fifth_third_a: assert property (
      settled && prim_ff == PRIM_USE_EXT && ext_ff == EXT_FB2_TB1
      |-> filter_enable == 7'h60 && decim_factor == 6'h0f) else $error("code 8 decode wrong");
   half_fifth_a: assert property (
      settled && prim_ff == PRIM_USE_EXT && ext_ff == EXT_HB2_FB2
      |-> filter_enable == 7'h62 && decim_factor == 6'h1e) else $error("code 9 decode wrong");
   primary_gate_a: assert property (
      settled && prim_ff == 3'h0 && !c2r_ff |-> filter_enable == 7'h03 && decim_factor == 6'h04)
      else $error("extended field leaked into primary decode");

   cover property (wr_done && paddr == OSC_CTRL_ADDR);
   cover property (settled && mode_ff == MODE_EDGE_A && $changed(active_channel));
   cover property (pready && pslverr);
endmodule
bind ddc_input_and_nco_channel_select ddc_sel_assertions ddc_sel_assertions_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .select_pin_low(select_pin_low), .select_pin_high(select_pin_high),
   .i_source_b(i_source_b), .q_source_b(q_source_b), .active_channel(active_channel),
   .filter_enable(filter_enable), .decim_factor(decim_factor));
`default_nettype wire

// [dv/ddc_input_and_nco_channel_select_tb_top.sv]
// Self-checking bench for the downconverter select block.
// Assumes the checker and pin partner files are compiled alongside it.
`timescale 1ns/100ps
`default_nettype none
module ddc_input_and_nco_channel_select_tb_top;
   import ddc_sel_pkg::*;
   typedef struct {
      logic [3:0] ctl;
      logic [3:0] ext;
      logic [6:0] filt;
      logic [5:0] fac;
      logic       uns;
   } row_t;
   logic        pclk = 1'b0;
   logic        presetn, ce, psel, penable, pwrite, er, req_low, req_high;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, pin_low, pin_high, i_b, q_b, c2r, uns, inv;
   logic [3:0]  chan;
   logic [6:0]  filt;
   logic [5:0]  fac;
   int          bad_count = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          e;
   logic [15:0] regs [3] = '{DECIM_CTRL_ADDR, INPUT_ROUTE_ADDR, OSC_CTRL_ADDR};
   row_t        rows [9] = '{'{4'h7, 4'h7, 7'h20, 6'h03, 1'b0}, '{4'h7, 4'h8, 7'h60, 6'h0f, 1'b0},
      '{4'h7, 4'h9, 7'h62, 6'h1e, 1'b0}, '{4'hf, 4'h7, 7'h20, 6'h03, 1'b1},
      '{4'hf, 4'h8, 7'h60, 6'h0f, 1'b1}, '{4'hf, 4'h9, 7'h62, 6'h1e, 1'b1},
      '{4'h0, 4'h9, 7'h03, 6'h04, 1'b0}, '{4'h8, 4'h7, 7'h03, 6'h02, 1'b0},
      '{4'h7, 4'h5, 7'h00, 6'h00, 1'b0}};

   initial begin
      forever #12.5 pclk = ~pclk;
   end

   ddc_input_and_nco_channel_select ddc_input_and_nco_channel_select_inst (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .select_pin_low(pin_low), .select_pin_high(pin_high),
      .i_source_b(i_b), .q_source_b(q_b), .active_channel(chan), .filter_enable(filt),
      .decim_factor(fac), .c2r_enable(c2r), .real_rate_unsupported(uns),
      .decim_code_invalid(inv));
   pin_partner pin_partner_inst (.pclk(pclk), .presetn(presetn), .req_low(req_low),
      .req_high(req_high), .select_pin_low(pin_low), .select_pin_high(pin_high));

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_compared++;
      if (got !== ex) begin
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
         bad_count++;
      end
   endtask

   // The request stands until pready is seen high at a rising edge.
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic pulse(input logic hi);
      @(posedge pclk);
      if (hi) req_high <= 1'b1;
      else req_low <= 1'b1;
      repeat (2) @(posedge pclk);
      req_high <= 1'b0;
      req_low  <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask

   task automatic check_reset;
      foreach (regs[k]) begin
         apb(1'b0, regs[k], 32'h0);
         chk("reg_reset", 32'h0, rd);
      end
      chk("route_outs_reset", 32'h0, {30'h0, q_b, i_b});
      chk("chan_reset", 32'h0, 32'(chan));
      chk("filt_reset", 32'h03, 32'(filt));
      chk("fac_reset", 32'h04, 32'(fac));
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      {presetn, psel, penable, pwrite, req_low, req_high} = 6'h00;
      ce = 1'b1;
      paddr = 16'h0000;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check_reset();
      foreach (rows[k]) begin
         apb(1'b1, DECIM_CTRL_ADDR, {28'h0, rows[k].ctl});
         apb(1'b1, INPUT_ROUTE_ADDR, {24'h0, rows[k].ext, 4'h0});
         repeat (3) @(posedge pclk);
         chk("filter_enable", 32'(rows[k].filt), 32'(filt));
         chk("decim_factor", 32'(rows[k].fac), 32'(fac));
         chk("real_unsupported", 32'(rows[k].uns), 32'(uns));
         chk("c2r_enable", 32'(rows[k].ctl[3]), 32'(c2r));
         chk("code_invalid", 32'(rows[k].filt == 7'h00), 32'(inv));
      end
      apb(1'b1, INPUT_ROUTE_ADDR, 32'hff);
      apb(1'b0, INPUT_ROUTE_ADDR, 32'h0);
      chk("route_read", 32'hf5, rd);
      chk("route_both_b", 32'h3, {30'h0, q_b, i_b});
      apb(1'b1, INPUT_ROUTE_ADDR, 32'h04);
      repeat (3) @(posedge pclk);
      chk("route_q_only", 32'h2, {30'h0, q_b, i_b});
      apb(1'b0, 16'h0000, 32'h0);
      chk("unmapped_err", 32'h1, 32'(er));
      chk("unmapped_data", 32'h0, rd);
      apb(1'b1, SEL_STATUS_ADDR, 32'hff);
      for (int v = 13; v < 16; v += 2) begin
         apb(1'b1, OSC_CTRL_ADDR, 32'(v));
         repeat (3) @(posedge pclk);
         chk("reg_channel", 32'(v), 32'(chan));
         apb(1'b0, SEL_STATUS_ADDR, 32'h0);
         chk("status_channel", 32'(v), {28'h0, rd[3:0]});
      end
      apb(1'b1, OSC_CTRL_ADDR, 32'h10);
      for (int v = 0; v < 4; v++) begin
         req_low  <= v[0];
         req_high <= v[1];
         repeat (6) @(posedge pclk);
         chk("pin_channel", 32'(v), 32'(chan));
      end
      req_low  <= 1'b0;
      req_high <= 1'b0;
      // Mode 8 steps on the low pin up to 2, mode 0xa on the high pin up to 3.
      for (int m = 0; m < 2; m++) begin
         apb(1'b1, OSC_CTRL_ADDR, 32'h0);
         apb(1'b1, OSC_CTRL_ADDR, (m == 1) ? 32'ha3 : 32'h82);
         repeat (4) @(posedge pclk);
         e = 0;
         for (int n = 0; n < 5; n++) begin
            pulse(m[0]);
            e = (e == 2 + m) ? 0 : e + 1;
            chk("edge_step", 32'(e), 32'(chan));
         end
         pulse(!m[0]);
         chk("other_pin_ignored", 32'(e), 32'(chan));
      end
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check_reset();
      stop_test();
   end
endmodule
`default_nettype wire
